// >>> logic/tws_core.sv
// execution of table write, test file skip zero and xor literal working
//
// Function
// - post-increment: write holding, then pointer plus one
// - pre-increment: pointer plus one, then write holding
// - pointer low three bits pick holding register
// - zero operand discards prefetched instruction as nop
// - one cycle, or two when skipping
// - skipping two-word instruction takes three cycles
// - bank bit picks access bank or bank select
// - extended set: low file addresses are indexed when bank bit is clear
// - xor literal into working reg, sets n and z
//
// timing of one execute slot
// - an instruction retires at the rising edge where i_cyc_en is high and the
//   slot is live; edges without the enable change no state at all
// - table write: pointer and the chosen holding byte settle at that edge
// - test file skip zero: o_dmem is driven combinationally in the slot, so the
//   data memory has to return i_file_data within the same clock cycle
// - a zero operand arms the skip sequencer; the next one or two enabled
//   slots are flushed and their opcodes ignored, with o_flush and o_busy high
// - xor literal working: working register, n and z settle at the edge
//
// limitations
// - the holding bytes are only collected here; moving them into program
//   memory is handled outside this block
// - only three instructions are decoded; every other opcode is a no-operation
// - the indexed operand address wraps inside eight bits of i_fsr2_base, which
//   keeps the adder narrow; software must not rely on a carry into the bank
// - the post-decrement table write mode is carried for completeness of the
//   mode field even though no rule here asks for it
// - a reset in the middle of a skip drops the pending nop slots
//
// trade-offs
// - the operand request is combinational to save a cycle of latency; a slow
//   data memory has to be met by stretching the instruction cycle enable
// - the skip sequencer walks three codes in a loop, so one step cannot be a
//   single bit change; the spare code falls back to run
// - the holding registers are a plain array rather than a memory macro, since
//   eight bytes are cheaper in flops than a wrapper
// - flags other than n and z belong to the status register outside; this
//   block only reports the two that xor literal working may change
`timescale 1ns/1ns
`default_nettype none
module tws_core
   import tws_pkg::*;
#(
   parameter int PTR_W = 21
)
(
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_cyc_en,          // one pulse per instruction cycle
   input  wire logic [15:0]      i_opcode,          // instruction in execute this cycle
   input  wire logic             i_next_two_word,   // prefetched instruction is two words
   input  wire logic [7:0]       i_table_latch,
   input  wire logic [3:0]       i_bank_select_register,
   input  wire logic             i_ext_en,
   input  wire logic [7:0]       i_fsr2_base,
   input  wire logic [7:0]       i_file_data,       // operand read from data memory
   output tws_dmem_s             o_dmem,
   output logic [PTR_W-1:0]      o_table_pointer,
   output logic [8*HOLD_NUM-1:0] o_hold,
   output logic [7:0]            o_wreg,
   output logic                  o_flag_n,
   output logic                  o_flag_z,
   output logic                  o_flush,           // current execute slot is a forced nop
   output logic                  o_busy
);
   // refuse a pointer not at least one bit wider than the holding register select
   if (PTR_W < HOLD_SEL_W + 1)
   begin : g_ptr_w_check
      $error("PTR_W too small");
   end

   // architectural state
   logic [PTR_W-1:0]      table_pointer_r;
   logic [7:0]            hold_r [HOLD_NUM];
   logic [7:0]            wreg_r;
   logic                  flag_n_r;
   logic                  flag_z_r;
   tws_skip_e             skip_r;
   // decode and datapath
   logic                  is_tw;
   logic                  is_tst;
   logic                  is_xor;
   logic                  live;
   logic [PTR_W-1:0]      tp_inc;
   logic [PTR_W-1:0]      tp_dec;
   logic [7:0]            xor_res;
   logic [11:0]           addr;
   logic                  indexed;
   logic [HOLD_SEL_W-1:0] hold_sel;

   ////////////////////////////////////////////////////////////////////////////
   // decode; a slot being skipped executes nothing
   function automatic logic op_match(input logic [15:0] op, input logic [15:0] m,
                                     input logic [15:0] v);
      op_match = (op & m) == v;
   endfunction

   // holding register picked by a table write; pre-increment uses the new pointer
   function automatic logic [HOLD_SEL_W-1:0] hold_pick(input logic [1:0]       mode,
                                                       input logic [PTR_W-1:0] now,
                                                       input logic [PTR_W-1:0] ahead);
      hold_pick = (mode == TW_PREINC) ? ahead[HOLD_SEL_W-1:0]
                                      : now[HOLD_SEL_W-1:0];
   endfunction

   assign live    = i_cyc_en && (skip_r == SK_RUN);
   assign is_tw   = live && op_match(i_opcode, OPC_TBLWR_MASK, OPC_TBLWR);
   assign is_tst  = live && op_match(i_opcode, OPC_TSTSZ_MASK, OPC_TSTSZ);
   assign is_xor  = live && op_match(i_opcode, OPC_XORL_MASK, OPC_XORL);
   assign tp_inc  = table_pointer_r + PTR_W'(1);
   assign tp_dec  = table_pointer_r - PTR_W'(1);
   assign xor_res = wreg_r ^ i_opcode[7:0];
   // one index for the write port, whichever table write form is running
   assign hold_sel = hold_pick(i_opcode[1:0], table_pointer_r, tp_inc);

   tws_addr_gen u_addr (
      .i_file                 (i_opcode[7:0]),
      .i_bank_bit             (i_opcode[BANK_BIT]),
      .i_bank_select_register (i_bank_select_register),
      .i_ext_en               (i_ext_en),
      .i_fsr2_base            (i_fsr2_base),
      .o_addr                 (addr),
      .o_indexed              (indexed)
   );

   // operand request goes out only for test file skip zero
   always_comb
   begin
      o_dmem.valid   = is_tst;
      o_dmem.indexed = indexed;
      o_dmem.addr    = addr;
   end

   ////////////////////////////////////////////////////////////////////////////
   // table pointer update
   // the post-decrement form is decoded too, so every mode code is served
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         table_pointer_r <= PTR_W'(TP_RST);
      else if (is_tw)
      begin
         unique case (i_opcode[1:0])
            TW_NOCHG:   table_pointer_r <= table_pointer_r;
            TW_POSTINC: table_pointer_r <= tp_inc;
            TW_POSTDEC: table_pointer_r <= tp_dec;
            TW_PREINC:  table_pointer_r <= tp_inc;
         endcase
      end
   end

   // holding register write; pre-increment uses the advanced pointer
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < HOLD_NUM; i++)
            hold_r[i] <= HOLD_RST;
      end
      else if (is_tw)
         hold_r[hold_sel] <= i_table_latch;
   end

   ////////////////////////////////////////////////////////////////////////////
   // working register and flags; other flags untouched since only n, z live here
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wreg_r   <= W_RST;
         flag_n_r <= 1'b0;
         flag_z_r <= 1'b0;
      end
      else if (is_xor)
      begin
         wreg_r   <= xor_res;
         flag_n_r <= xor_res[7];
         flag_z_r <= (xor_res == 8'h00);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // skip sequencer: the operand arrives combinationally in the execute cycle
   // the sequencer only steps on enabled edges, so a slowed instruction clock
   // still flushes exactly one or two whole slots
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         skip_r <= SK_RUN;
      else if (i_cyc_en)
      begin
         unique case (skip_r)
            SK_RUN:
            begin
               if (is_tst && (i_file_data == 8'h00))
                  skip_r <= i_next_two_word ? SK_NOP2 : SK_NOP1;
            end
            SK_NOP2: skip_r <= SK_NOP1;
            SK_NOP1: skip_r <= SK_RUN;
            default: skip_r <= SK_RUN;
         endcase
      end
   end

   // outputs
   // o_busy mirrors o_flush so a fetch unit can stall without decoding
   always_comb
   begin
      o_table_pointer = table_pointer_r;
      o_wreg          = wreg_r;
      o_flag_n        = flag_n_r;
      o_flag_z        = flag_z_r;
      o_flush         = (skip_r != SK_RUN);
      o_busy          = (skip_r != SK_RUN);
      for (int i = 0; i < HOLD_NUM; i++)
         o_hold[8*i +: 8] = hold_r[i];
   end
endmodule
`default_nettype wire

// >>> logic/tws_pkg.sv
// package for the table write / test skip / xor literal execution block
package tws_pkg;
   // opcode patterns and masks
   localparam logic [15:0] OPC_TBLWR_MASK  = 16'hfffc;
   localparam logic [15:0] OPC_TBLWR       = 16'h000c;
   localparam logic [15:0] OPC_TSTSZ_MASK  = 16'hfe00;
   localparam logic [15:0] OPC_TSTSZ       = 16'h6600;
   localparam logic [15:0] OPC_XORL_MASK   = 16'hff00;
   localparam logic [15:0] OPC_XORL        = 16'h0a00;
   // table write modes in the low two opcode bits
   localparam logic [1:0]  TW_NOCHG        = 2'h0;
   localparam logic [1:0]  TW_POSTINC      = 2'h1;
   localparam logic [1:0]  TW_POSTDEC      = 2'h2;
   localparam logic [1:0]  TW_PREINC       = 2'h3;
   // field positions
   localparam int          BANK_BIT        = 8;
   localparam int          HOLD_SEL_W      = 3;
   localparam int          HOLD_NUM        = 8;
   // highest indexed literal offset address
   localparam logic [7:0]  ILO_LIMIT       = 8'h5f;
   localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;
   localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
   // reset values
   localparam logic [20:0] TP_RST          = 21'h000000;
   localparam logic [7:0]  W_RST           = 8'h00;
   localparam logic [7:0]  HOLD_RST        = 8'hff;

   // data memory address request
   typedef struct packed {
      logic        valid;
      logic        indexed;   // indexed literal offset operand
      logic [11:0] addr;
   } tws_dmem_s;

   // skip state: idle, one nop, two nops
   typedef enum logic [1:0] {
      SK_RUN  = 2'b00,
      SK_NOP1 = 2'b01,
      SK_NOP2 = 2'b11
   } tws_skip_e;
endpackage

// >>> logic/tws_addr_gen.sv
// data memory address former for file operands
`timescale 1ns/1ns
`default_nettype none
module tws_addr_gen
   import tws_pkg::*;
(
   input  wire logic [7:0]  i_file,
   input  wire logic        i_bank_bit,
   input  wire logic [3:0]  i_bank_select_register,
   input  wire logic        i_ext_en,
   input  wire logic [7:0]  i_fsr2_base,
   output logic      [11:0] o_addr,
   output logic             o_indexed
);
   // access bank splits at 60h; bank bit set uses bank select register
   always_comb
   begin
      o_indexed = 1'b0;
      if (i_bank_bit)
         o_addr = {i_bank_select_register, i_file};
      else if (i_ext_en && (i_file <= ILO_LIMIT))
      begin
         o_indexed = 1'b1;
         o_addr    = {4'h0, i_fsr2_base + i_file};
      end
      else if (i_file < ACCESS_SPLIT)
         o_addr = {4'h0, i_file};
      else
         o_addr = {ACCESS_HI_BANK, i_file};
   end
endmodule
`default_nettype wire

// >>> dv/tws_chk.sv
// concurrent checks on the tws_core ports
`timescale 1ns/1ns
`default_nettype none
module tws_chk
   import tws_pkg::*;
#(
   parameter int PTR_W = 21
)
(
   input wire logic                    i_ref_clk,
   input wire logic                    i_rst_n,
   input wire logic                    i_cyc_en,
   input wire logic [15:0]             i_opcode,
   input wire logic                    i_next_two_word,
   input wire logic [7:0]              i_table_latch,
   input wire logic [3:0]              i_bank_select_register,
   input wire logic                    i_ext_en,
   input wire logic [7:0]              i_file_data,
   input wire tws_dmem_s               o_dmem,
   input wire logic [PTR_W-1:0]        o_table_pointer,
   input wire logic [8*HOLD_NUM-1:0]   o_hold,
   input wire logic [7:0]              o_wreg,
   input wire logic                    o_flag_n,
   input wire logic                    o_flag_z,
   input wire logic                    o_flush
);
   ////////////////////////////////////////
   // live slot decode; a flushed slot must never count as an instruction
   wire logic       live = i_cyc_en && !o_flush;
   wire logic       tst  = live && (i_opcode & OPC_TSTSZ_MASK) == OPC_TSTSZ;
   wire logic       xorl = live && (i_opcode & OPC_XORL_MASK) == OPC_XORL;
   wire logic [2:0] tp_lo = o_table_pointer[2:0];
   wire logic [7:0] f    = i_opcode[7:0];
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_skip(tw);
      tst && i_file_data == 8'h00 && i_next_two_word == tw;
   endsequence
   ////////////////////////////////////////
   // table write, skip timing, addressing and xor
   property p_post;
      live && i_opcode == 16'h000d |=> o_table_pointer == $past(o_table_pointer) + 1'b1
         && o_hold[{$past(tp_lo), 3'h0} +: 8] == $past(i_table_latch);
   endproperty
   a_post: assert property (p_post) else $error("post-increment write wrong");
   property p_pre;
      live && i_opcode == 16'h000f |=> o_table_pointer == $past(o_table_pointer) + 1'b1
         && o_hold[{tp_lo, 3'h0} +: 8] == $past(i_table_latch);
   endproperty
   a_pre: assert property (p_pre) else $error("pre-increment write wrong");
   property p_run;
      tst && i_file_data != 8'h00 |=> !o_flush;
   endproperty
   a_run: assert property (p_run) else $error("skip on nonzero operand");
   property p_two;
      s_skip(1'b0) ##1 i_cyc_en |=> !o_flush && $past(o_flush);
   endproperty
   a_two: assert property (p_two) else $error("one-word skip length wrong");
   property p_three;
      s_skip(1'b1) ##1 i_cyc_en [*2] |=> !o_flush && $past(o_flush);
   endproperty
   a_three: assert property (p_three) else $error("two-word skip length wrong");
   property p_bank;
      o_dmem.valid && !o_dmem.indexed |-> o_dmem.addr == (i_opcode[8] ?
         {i_bank_select_register, f} : {f < ACCESS_SPLIT ? 4'h0 : ACCESS_HI_BANK, f});
   endproperty
   a_bank: assert property (p_bank) else $error("bank address wrong");
   property p_ilo;
      o_dmem.valid |-> o_dmem.indexed == (!i_opcode[8] && i_ext_en && f <= ILO_LIMIT);
   endproperty
   a_ilo: assert property (p_ilo) else $error("indexed mode choice wrong");
   property p_xor;
      xorl |=> o_wreg == ($past(o_wreg) ^ $past(f)) && o_flag_n == o_wreg[7]
         && o_flag_z == (o_wreg == 8'h00);
   endproperty
   a_xor: assert property (p_xor) else $error("xor literal result wrong");
endmodule
bind tws_core tws_chk #(.PTR_W(PTR_W)) u_chk (.*);
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for tws_core
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import tws_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b1, tw = 1'b0, ext = 1'b0, fn, fz, fl, bz;
   logic [15:0] op = 16'h0000;
   logic [7:0]  fd = 8'h00, w = 8'h00, ow;
   logic [3:0]  bank_select_register = 4'h0;
   logic [20:0] tp = 21'h000000, otp;
   logic [63:0] hx = 64'hffffffffffffffff, oh;
   tws_dmem_s   dm;
   int          bad_count = 0, comparisons = 0, ticks = 0;
   tws_core dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cyc_en(cyc), .i_opcode(op),
      .i_next_two_word(tw), .i_table_latch(fd), .i_bank_select_register(bank_select_register), .i_ext_en(ext),
      .i_fsr2_base(8'h10), .i_file_data(fd), .o_dmem(dm), .o_table_pointer(otp), .o_hold(oh),
      .o_wreg(ow), .o_flag_n(fn), .o_flag_z(fz), .o_flush(fl), .o_busy(bz));
   ////////////////////////////////////////
   // clock and shared tasks
   initial forever #25 clk = ~clk;
   task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
      comparisons++;
      if (s !== e)
      begin
         bad_count++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask
   // nx is parked in the slot after, so a skip has a real instruction to drop
   task automatic ex(logic [15:0] o, logic [7:0] f, logic t = 1'b0, logic [15:0] nx = 16'h0);
      @(posedge clk);
      op <= o;
      fd <= f;
      tw <= t;
      @(posedge clk);
      op <= nx;
      @(negedge clk);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   // scenarios
   task automatic t_table;
      logic [1:0] md [12] = '{1, 1, 1, 1, 1, 1, 3, 1, 0, 2, 2, 3};
      for (int i = 0; i < 12; i++)
      begin
         if (md[i] == 2'h3) tp++;
         hx[8*tp[2:0] +: 8] = 8'h30 + 8'(i);
         if (md[i] == 2'h1) tp++;
         if (md[i] == 2'h2) tp--;
         ex({14'h0003, md[i]}, 8'h30 + 8'(i));
         chk("pointer", 64'(otp), 64'(tp));
         chk("holding", oh, hx);
      end
      $display("table write test done");
   endtask
   task automatic t_xor;
      logic [7:0] k [4] = '{8'h5a, 8'hff, 8'ha5, 8'h0f};
      foreach (k[i])
      begin
         w ^= k[i];
         ex({8'h0a, k[i]}, 8'h00);
         chk("wreg", 64'(ow), 64'(w));
         chk("flags", 64'({fn, fz}), 64'({w[7], w == 8'h00}));
      end
      // no enable, no execution: the working register must hold
      @(posedge clk);
      cyc <= 1'b0;
      ex(16'h0a55, 8'h00);
      chk("gated wreg", 64'(ow), 64'(w));
      @(posedge clk);
      cyc <= 1'b1;
      $display("xor test done");
   endtask
   task automatic t_skip;
      ex(16'h6601, 8'h07, 1'b0, 16'h0a01);
      chk("flush", 64'(fl), 64'h0);
      w ^= 8'h01;
      ex(16'h6601, 8'h00, 1'b0, 16'h0aff);
      chk("flush", 64'(fl), 64'h1);
      chk("busy", 64'(bz), 64'h1);
      ex(16'h6601, 8'h00, 1'b1, 16'h0a80);
      chk("flush", 64'(fl), 64'h1);
      ex(16'h0a3c, 8'h00);
      chk("flush", 64'(fl), 64'h0);
      chk("wreg", 64'(ow), 64'(w));
      $display("skip test done");
   endtask
   // fields: bank bit, file, extended, bank select, indexed, address
   task automatic t_addr;
      logic [26:0] cs [6] = '{{1'b1, 8'h23, 1'b0, 4'h5, 13'h0523},
         {1'b0, 8'h23, 1'b0, 4'h5, 13'h0023}, {1'b0, 8'h80, 1'b0, 4'h5, 13'h0f80},
         {1'b0, 8'h5f, 1'b1, 4'h5, 13'h106f}, {1'b0, 8'h60, 1'b1, 4'h5, 13'h0f60},
         {1'b1, 8'h10, 1'b1, 4'ha, 13'h0a10}};
      foreach (cs[i])
      begin
         @(posedge clk);
         bank_select_register <= cs[i][16:13];
         ext <= cs[i][17];
         ex(16'h0000, 8'h01, 1'b0, {7'h33, cs[i][26:18]});
         chk("valid", 64'(dm.valid), 64'h1);
         chk("indexed", 64'(dm.indexed), 64'(cs[i][12]));
         chk("address", 64'(dm.addr), 64'(cs[i][11:0]));
      end
      $display("address test done");
   endtask
   // reset mid-run, while one nop slot is still pending, must return every register to its reset value
   task automatic t_reset;
      ex(16'h6601, 8'h00, 1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("reset flush", 64'({fl, bz}), 64'h0);
      chk("reset state", 64'({otp, ow, fn, fz}), 64'h0);
      chk("reset hold", oh, 64'hffffffffffffffff);
      $display("reset test done");
   endtask
   // main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("reset", 64'({otp, ow, fn, fz, fl, bz}), 64'h0);
      chk("reset hold", oh, hx);
      t_table;
      t_xor;
      t_skip;
      t_addr;
      t_reset;
      tally_and_finish;
   end
   // hang guard, far above the fewer than one hundred cycles the run needs
   always @(posedge clk)
   begin
      ticks++;
      if (ticks == 2000)
      begin
         bad_count++;
         tally_and_finish;
      end
   end
endmodule
`default_nettype wire
